// file: sim/pxw_master.sv
// Purpose: Bus master model for the write path
// Assumes: Pull-up on SDA; master owns SCL
// Notes:   SCL stands high between frames
`timescale 1ns/10ps

module pxw_master
(
    input  wire logic clock_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    localparam int HALF = 8;

    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic tick();
        repeat (HALF) @(posedge clock_i);
        #1;
    endtask : tick

    task automatic start_bit();
        sda_o = 1'b1;
        tick();
        scl_o = 1'b1;
        tick();
        sda_o = 1'b0;
        tick();
        scl_o = 1'b0;
        tick();
    endtask : start_bit

    // Ends the frame, leaves SCL high
    task automatic stop_bit();
        sda_o = 1'b0;
        tick();
        scl_o = 1'b1;
        tick();
        sda_o = 1'b1;
        tick();
    endtask : stop_bit

    // MSB first, then releases SDA for the acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sda_o = b[i];
            tick();
            scl_o = 1'b1;
            tick();
            scl_o = 1'b0;
        end
        sda_o = 1'b1;
        tick();
        scl_o = 1'b1;
        tick();
        ack = ~sda_i;
        scl_o = 1'b0;
    endtask : send_byte
endmodule : pxw_master

// file: sim/tb.sv
// Purpose: Self-checking bench of the write path
// Assumes: Address select 4'h5 unless a scenario moves it between frames
// Notes:   One task a scenario
`timescale 1ns/10ps

module tb;
    import pxw_pkg::*;
    logic       clock_i;
    logic       reset_i;
    logic       scl;
    logic       m_sda;
    logic       ev;
    logic       oe;
    logic       al_oe;
    logic       clr;
    logic       ack;
    logic [3:0] pin;
    logic [7:0] pout;
    logic [3:0] mask;
    logic [3:0] smp;
    logic       sdo;
    logic       alo;
    logic [3:0] asel;
    wire        sda = m_sda & ~(oe & ~sdo);
    wire        alert_n = ~(al_oe & ~alo);
    int         n_fail = 0;
    int         samples_checked = 0;
    int         n_clr = 0;

    pxw_master i_pxw_master (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));

    pxw_write_path i_pxw_write_path (.clock_i(clock_i), .reset_i(reset_i), .scl_i(scl),
        .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe), .addr_sel_i(asel), .port_in_i(pin),
        .change_event_i(ev), .port_out_o(pout), .int_mask_o(mask), .input_sample_o(smp),
        .flags_clear_o(clr), .alert_o(alo), .alert_oe_o(al_oe));

    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    always @(posedge clock_i)
        if (clr === 1'b1) n_clr++;

    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    task automatic t_reset();
        check("port_out", 8'hFF, pout);
        check("int_mask", 8'h00, {4'h0, mask});
        check("sda_oe", 8'h00, {7'h0, oe});
    endtask : t_reset

    task automatic t_write();
        pin = 4'hA;
        i_pxw_master.start_bit();
        i_pxw_master.send_byte(8'hCA, ack);
        check("addr_ack", 8'h01, {7'h0, ack});
        check("sample", 8'h0A, {4'h0, smp});
        check("clears", 8'h01, n_clr[7:0]);
        i_pxw_master.send_byte(8'h5A, ack);
        check("ack1", 8'h01, {7'h0, ack});
        check("port_out", 8'h5A, pout);
        i_pxw_master.send_byte(8'h3C, ack);
        check("mask2", 8'h0F, {4'h0, mask});
        i_pxw_master.send_byte(8'h14, ack);
        check("ack3", 8'h01, {7'h0, ack});
        check("mask3", 8'h05, {4'h0, mask});
        check("port_keep", 8'h5A, pout);
        i_pxw_master.stop_bit();
        check("sda_rel", 8'h00, {7'h0, oe});
    endtask : t_write

    task automatic t_alert();
        @(posedge clock_i) #1 ev = 1'b1;
        @(posedge clock_i) #1 ev = 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
        check("alert_on", 8'h01, {7'h0, al_oe});
        check("alert_pin", 8'h00, {7'h0, alert_n});
        pin = 4'h3;
        i_pxw_master.start_bit();
        i_pxw_master.send_byte(8'hCA, ack);
        check("alert_off", 8'h00, {7'h0, al_oe});
        check("sample2", 8'h03, {4'h0, smp});
        i_pxw_master.stop_bit();
        check("alert_clr", 8'h00, {7'h0, al_oe});
        check("alert_hi", 8'h01, {7'h0, alert_n});
    endtask : t_alert

    task automatic t_refuse();
        n_clr = 0;
        i_pxw_master.start_bit();
        i_pxw_master.send_byte(8'hCB, ack);
        check("read_nak", 8'h00, {7'h0, ack});
        i_pxw_master.stop_bit();
        i_pxw_master.start_bit();
        i_pxw_master.send_byte(8'hC8, ack);
        check("other_nak", 8'h00, {7'h0, ack});
        i_pxw_master.send_byte(8'h00, ack);
        check("data_nak", 8'h00, {7'h0, ack});
        i_pxw_master.stop_bit();
        check("port_same", 8'h5A, pout);
        check("no_clear", 8'h00, n_clr[7:0]);
    endtask : t_refuse

    // Other address select, then a repeated START inside a data phase
    task automatic t_restart();
        asel = 4'h4;
        i_pxw_master.start_bit();
        i_pxw_master.send_byte(8'hC8, ack);
        check("ack_sel", 8'h01, {7'h0, ack});
        i_pxw_master.send_byte(8'h81, ack);
        check("ack_a", 8'h01, {7'h0, ack});
        check("port_a", 8'h81, pout);
        i_pxw_master.start_bit();
        i_pxw_master.send_byte(8'hC8, ack);
        check("ack_rs", 8'h01, {7'h0, ack});
        i_pxw_master.send_byte(8'h42, ack);
        check("port_rs", 8'h42, pout);
        check("mask_rs", 8'h05, {4'h0, mask});
        i_pxw_master.stop_bit();
        check("sda_rel2", 8'h00, {7'h0, oe});
        asel = 4'h5;
    endtask : t_restart

    initial
    begin
        #100000;
        n_fail++;
        close_out();
    end

    initial
    begin
        reset_i = 1'b1;
        ev = 1'b0;
        pin = 4'h0;
        asel = 4'h5;
        repeat (2) @(posedge clock_i);
        #1 reset_i = 1'b0;
        t_reset();
        t_write();
        t_alert();
        t_refuse();
        t_restart();
        close_out();
    end
endmodule : tb

// file: verilog/pxw_map.svh
// Purpose: Constants of the port expander write path
// Assumes: Included by the write path design files
// Notes:   Definitions only
`ifndef PXW_MAP_SVH
`define PXW_MAP_SVH

`define PXW_ADDR_FIXED    3'h6
`define PXW_RW_WRITE      1'b0
`define PXW_BITS_PER_BYTE 4'h8
`define PXW_OUT_RESET     8'hFF
`define PXW_MASK_RESET    4'h0
`define PXW_MASK_LSB      2
`define PXW_MASK_MSB      5

`endif

// file: verilog/pxw_pin_sync.sv
// Purpose: Two-stage synchroniser for the bus and port pins
// Assumes: Pins are asynchronous to clock_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps

module pxw_pin_sync
    import pxw_pkg::*;
(
    input  wire logic         clock_i,
    input  wire logic         reset_i,
    input  wire pxw_pins_type pins_i,
    output pxw_pins_type      pins_o
);

    pxw_pins_type stage_one;

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            stage_one <= '{scl: 1'b1, sda: 1'b1, ports: 4'hF};
            pins_o    <= '{scl: 1'b1, sda: 1'b1, ports: 4'hF};
        end
        else
        begin
            stage_one <= pins_i;
            pins_o    <= stage_one;
        end
    end

endmodule : pxw_pin_sync

// file: verilog/pxw_pkg.sv
// Purpose: Types of the port expander write path
// Assumes: Constants come from pxw_map.svh
// Notes:   One-hot state codes written out
package pxw_pkg;

    typedef struct packed {
        logic       scl;
        logic       sda;
        logic [3:0] ports;
    } pxw_pins_type;

    typedef enum logic [4:0] {
        PXW_IDLE     = 5'h01,
        PXW_ADDR     = 5'h02,
        PXW_ADDR_ACK = 5'h04,
        PXW_DATA     = 5'h08,
        PXW_DATA_ACK = 5'h10
    } pxw_state_type;

endpackage : pxw_pkg

// file: verilog/pxw_write_path.sv
// Purpose: Write transaction path of an I2C port expander slave
// Assumes: SCL and SDA far slower than clock_i; read path lives elsewhere
// Notes:   SDA and the alert line are open drain; enable high pulls low
`timescale 1ns/10ps
`include "pxw_map.svh"

module pxw_write_path
    import pxw_pkg::*;
#(
    parameter logic [7:0] OUT_RESET  = `PXW_OUT_RESET,
    parameter logic [3:0] MASK_RESET = `PXW_MASK_RESET
)
(
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic [3:0] addr_sel_i,
    input  wire logic [3:0] port_in_i,
    input  wire logic       change_event_i,
    output logic [7:0]      port_out_o,
    output logic [3:0]      int_mask_o,
    output logic [3:0]      input_sample_o,
    output logic            flags_clear_o,
    output logic            alert_o,
    output logic            alert_oe_o
);

    pxw_pins_type  pins_raw;
    pxw_pins_type  pins_s;
    pxw_state_type state;
    logic          scl_q;
    logic          sda_q;
    logic          scl_rise;
    logic          scl_fall;
    logic          start_det;
    logic          stop_det;
    logic [3:0]    bit_cnt;
    logic [7:0]    shift;
    logic          ack_begin;
    logic          addr_hit;
    logic          addr_ack_go;
    logic          byte_go;
    logic          first_byte;
    logic          alert_pend;

    assign pins_raw = '{scl: scl_i, sda: sda_i, ports: port_in_i};

    pxw_pin_sync u_sync
    (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .pins_i  (pins_raw),
        .pins_o  (pins_s)
    );

    // Edge history of the synchronised bus lines
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= pins_s.scl;
            sda_q <= pins_s.sda;
        end
    end

    assign scl_rise  = pins_s.scl & ~scl_q;
    assign scl_fall  = ~pins_s.scl & scl_q;
    assign start_det = scl_q & pins_s.scl & sda_q & ~pins_s.sda;
    assign stop_det  = scl_q & pins_s.scl & ~sda_q & pins_s.sda;
    assign ack_begin = scl_fall && (bit_cnt == `PXW_BITS_PER_BYTE);
    assign addr_hit  = (shift[7:1] == {`PXW_ADDR_FIXED, addr_sel_i})
                       && (shift[0] == `PXW_RW_WRITE);
    assign addr_ack_go = (state == PXW_ADDR) && ack_begin && addr_hit;
    assign byte_go     = (state == PXW_DATA) && ack_begin;

    // Transfer sequencing
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            state <= PXW_IDLE;
        else if (stop_det)
            state <= PXW_IDLE;
        else if (start_det)
            state <= PXW_ADDR;
        else
        begin
            unique case (state)
                PXW_IDLE:
                    state <= PXW_IDLE;
                PXW_ADDR:
                    if (ack_begin)
                        state <= addr_hit ? PXW_ADDR_ACK : PXW_IDLE;
                PXW_ADDR_ACK:
                    if (scl_fall)
                        state <= PXW_DATA;
                PXW_DATA:
                    if (ack_begin)
                        state <= PXW_DATA_ACK;
                PXW_DATA_ACK:
                    if (scl_fall)
                        state <= PXW_DATA;
            endcase
        end
    end

    // Bit counter and shift register, MSB first
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
        end
        else if (start_det || (scl_fall && (state == PXW_ADDR_ACK
                                         || state == PXW_DATA_ACK)))
            bit_cnt <= 4'h0;
        else if (scl_rise && (state == PXW_ADDR || state == PXW_DATA)
                 && (bit_cnt != `PXW_BITS_PER_BYTE))
        begin
            bit_cnt <= bit_cnt + 4'h1;
            shift   <= {shift[6:0], pins_s.sda};
        end
    end

    // Acknowledge drive: SDA pulled low only in the ack bit periods
    assign sda_o    = 1'b0;
    assign sda_oe_o = (state == PXW_ADDR_ACK) || (state == PXW_DATA_ACK);

    // Byte position within the transfer
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            first_byte <= 1'b0;
        else if (addr_ack_go)
            first_byte <= 1'b1;
        else if (byte_go)
            first_byte <= 1'b0;
    end

    // Output levels, all eight loaded together
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            port_out_o <= OUT_RESET;
        else if (byte_go && first_byte)
            port_out_o <= shift;
    end

    // Interrupt mask from every later byte
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            int_mask_o <= MASK_RESET;
        else if (byte_go && !first_byte)
            int_mask_o <= shift[`PXW_MASK_MSB:`PXW_MASK_LSB];
    end

    // Input snapshot and flag clear at address acknowledge
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            input_sample_o <= 4'h0;
            flags_clear_o  <= 1'b0;
        end
        else
        begin
            flags_clear_o <= addr_ack_go;
            if (addr_ack_go)
                input_sample_o <= pins_s.ports;
        end
    end

    // Alert latch: cleared by the address acknowledge
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            alert_pend <= 1'b0;
        else if (addr_ack_go)
            alert_pend <= 1'b0;
        else if (change_event_i)
            alert_pend <= 1'b1;
    end

    assign alert_o    = 1'b0;
    assign alert_oe_o = alert_pend && (state != PXW_ADDR_ACK);

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    sequence s_addr_ack_start;
        (state == PXW_ADDR) && ack_begin && addr_hit;
    endsequence

    sequence s_byte_end;
        (state == PXW_DATA) && ack_begin;
    endsequence

    property p_addr_ack;
        s_addr_ack_start |=> sda_oe_o && (state == PXW_ADDR_ACK);
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address not acknowledged");

    property p_sample;
        s_addr_ack_start |=> input_sample_o == $past(pins_s.ports);
    endproperty
    a_sample: assert property (p_sample)
        else $error("inputs not sampled at address ack");

    property p_alert_release;
        (state == PXW_ADDR_ACK) |-> !alert_oe_o;
    endproperty
    a_alert_release: assert property (p_alert_release)
        else $error("alert driven during address ack");

    property p_data_ack;
        s_byte_end |=> sda_oe_o throughout (!scl_fall [*1]);
    endproperty
    a_data_ack: assert property (p_data_ack)
        else $error("data byte not acknowledged");

    property p_mask;
        s_byte_end ##0 !first_byte |=>
            int_mask_o == $past(shift[`PXW_MASK_MSB:`PXW_MASK_LSB]);
    endproperty
    a_mask: assert property (p_mask)
        else $error("mask not loaded from later byte");

    property p_outputs;
        s_byte_end ##0 first_byte |=> port_out_o == $past(shift);
    endproperty
    a_outputs: assert property (p_outputs)
        else $error("outputs not loaded from first byte");

    property p_flags;
        s_addr_ack_start |=> flags_clear_o ##1 !flags_clear_o;
    endproperty
    a_flags: assert property (p_flags)
        else $error("flag clear pulse wrong");

    property p_stop;
        stop_det |=> (state == PXW_IDLE) && !sda_oe_o;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not end transfer");

    property p_hold;
        !byte_go |=> $stable(port_out_o) && $stable(int_mask_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("port levels changed outside byte end");

endmodule : pxw_write_path
